//--- hdl/idc_cfg.svh
// Encodings and field positions for the integer decoder.
`ifndef IDC_CFG_SVH
`define IDC_CFG_SVH
`define IDC_OP_AAA 8'h37
`define IDC_OP_AAS 8'h3F
`define IDC_OP_AAD 8'hD5
`define IDC_OP_AAM 8'hD4
`define IDC_OP_ADJ2 8'h0A
`define IDC_OP_ADD_LO 8'h00
`define IDC_OP_ADD_HI 8'h05
`define IDC_OP_ADC_LO 8'h10
`define IDC_OP_ADC_HI 8'h15
`define IDC_OP_AND_RM8 8'h20
`define IDC_OP_GRP_B 8'h80
`define IDC_OP_GRP_W 8'h81
`define IDC_OP_GRP_SX 8'h83
`define IDC_GRP_ADD 3'h0
`define IDC_GRP_ADC 3'h2
`define IDC_GRP_AND 3'h4
`define IDC_MOD_REG 2'h3
`define IDC_MOD_HI 7
`define IDC_MOD_LO 6
`define IDC_REG_HI 5
`define IDC_REG_LO 3
`define IDC_RM_HI 2
`define IDC_RM_LO 0
`define IDC_DIR_BIT 1
`define IDC_WIDE_BIT 0
`define IDC_ACC_BIT 2
`define IDC_ACC_REG 3'h0
`define IDC_SIGN_BIT 7
`define IDC_NOPS 3
`endif

//--- hdl/idc_classify.sv
// Combinational classification of one instruction.
`timescale 1ns/1ps
`include "idc_cfg.svh"
module idc_classify import idc_pkg::*; (
  input wire idc_inst_t inst,
  input wire opsize32,
  output idc_dec_t dec
);
  wire [1:0] memory_form_code = inst.modrm[`IDC_MOD_HI:`IDC_MOD_LO];
  wire reg_form = (memory_form_code == `IDC_MOD_REG);
  // Memory only for 00b, 01b, 10b.
  wire mem_form = !reg_form;
  wire [2:0] sub = inst.modrm[`IDC_REG_HI:`IDC_REG_LO];
  wire is_adj1 = (inst.op1 == `IDC_OP_AAA) || (inst.op1 == `IDC_OP_AAS);
  // Two-byte adjust forms need the second byte.
  wire is_adj2 = ((inst.op1 == `IDC_OP_AAD) || (inst.op1 == `IDC_OP_AAM)) && (inst.op2 == `IDC_OP_ADJ2);
  wire is_add_rm = (inst.op1 >= `IDC_OP_ADD_LO) && (inst.op1 <= `IDC_OP_ADD_HI);
  wire is_adc_rm = (inst.op1 >= `IDC_OP_ADC_LO) && (inst.op1 <= `IDC_OP_ADC_HI);
  wire is_grp = (inst.op1 == `IDC_OP_GRP_B) || (inst.op1 == `IDC_OP_GRP_W) || (inst.op1 == `IDC_OP_GRP_SX);
  wire is_sx = (inst.op1 == `IDC_OP_GRP_SX);
  // Group sub-operation from modR/M bits 5..3.
  wire grp_add = is_grp && (sub == `IDC_GRP_ADD);
  wire grp_adc = is_grp && (sub == `IDC_GRP_ADC);
  wire grp_and = is_grp && (sub == `IDC_GRP_AND);
  wire is_acc = is_add_rm && inst.op1[`IDC_ACC_BIT];
  wire is_and20 = (inst.op1 == `IDC_OP_AND_RM8) && reg_form;
  wire arith = (is_add_rm || grp_add || grp_and || is_and20);
  // Accumulator forms carry no modR/M, so they count as register destinations.
  wire dest_mem = !is_acc && mem_form && (is_grp || !inst.op1[`IDC_DIR_BIT]);
  wire src_mem = !is_acc && mem_form && !dest_mem;
  wire wide = is_grp ? (inst.op1 != `IDC_OP_GRP_B) : inst.op1[`IDC_WIDE_BIT];
  // Byte arithmetic and sign-extended immediates go to X only.
  wire use_x = !wide || is_sx;
  wire idc_unit_t alu_u = use_x ? IDC_U_ALUX : IDC_U_ALU;
  wire is_vec = is_adj1 || is_adj2 || is_adc_rm || grp_adc;
  // Sign-extend the byte immediate to operand size.
  wire [31:0] sx32 = {{24{inst.byte_immediate[`IDC_SIGN_BIT]}}, inst.byte_immediate};
  wire [31:0] sx16 = {16'h0000, sx32[15:0]};

  // Field assembly; classes are mutually exclusive by construction.
  always_comb begin
    dec = '0;
    dec.valid = inst.valid;
    dec.mem_form = mem_form && !is_acc;
    dec.wide = wide;
    dec.opsize32 = opsize32;
    // Register index from modR/M bits 5..3 or accumulator.
    dec.reg_idx = is_acc ? `IDC_ACC_REG : sub;
    dec.rm_idx = inst.modrm[`IDC_RM_HI:`IDC_RM_LO];
    dec.sx_imm = is_sx;
    dec.imm_ext = is_sx ? (opsize32 ? sx32 : sx16) : {24'h000000, inst.byte_immediate};
    dec.func = grp_and || is_and20 ? IDC_F_AND : (arith ? IDC_F_ADD : IDC_F_NONE);
    if (!inst.valid) begin
      dec.cls = IDC_CLS_NONE;
    end else if (is_vec) begin
      // ADC and adjust forms are vector, no operations.
      dec.cls = IDC_CLS_VECTOR;
    end else if (arith && dest_mem) begin
      dec.cls = IDC_CLS_LONG;
      dec.nops = 2'd3;
      dec.ops[0] = IDC_U_LOAD;
      dec.ops[1] = alu_u;
      dec.ops[2] = IDC_U_STORE;
    end else if (arith) begin
      // Register destination is short; memory source adds a load.
      dec.cls = IDC_CLS_SHORT;
      dec.nops = src_mem ? 2'd2 : 2'd1;
      dec.ops[0] = src_mem ? IDC_U_LOAD : alu_u;
      dec.ops[1] = src_mem ? alu_u : IDC_U_NONE;
    end else begin
      // Opcodes outside this block go to the sequencer as vector.
      dec.cls = IDC_CLS_VECTOR;
    end
  end
endmodule // idc_classify

//--- hdl/idc_decoder.sv
// Top of the integer decoder: two lanes, class grouping and issue.
`timescale 1ns/1ps
`include "idc_cfg.svh"
// How it works
// - Per clock: two short, one long, or one vector.
// - One class each; adjust forms are vector.
// - modR/M top bits 11 mean register form.
// - Memory form only for 00, 01, 10.
// - Register index from modR/M bits 5..3.
// - Operand size picks word or doubleword width.
// - Group opcodes: 000 add, 010 adc, 100 and.
// - Every add-with-carry form is vector class.
// - Register-destination add is short; memory source loads.
// - Memory-destination add is long: load, alu, store.
// - Byte and sign-extended forms use X unit.
// - Wide arithmetic may use either integer unit.
// - Loads to load unit, stores to store unit.
module idc_decoder import idc_pkg::*; (
  input wire clk_sys,
  input wire reset_n,
  input wire clk_en,
  input wire idc_inst_t inst0,
  input wire idc_inst_t inst1,
  input wire opsize32,
  output logic [1:0] taken,
  output idc_dec_t dec0,
  output idc_dec_t dec1,
  output logic [3:0] unit0_a,
  output logic [3:0] unit0_b,
  output logic [3:0] unit0_c,
  output logic [3:0] unit1_a,
  output logic [3:0] unit1_b,
  output logic vec_start,
  output logic [7:0] vec_op1,
  output logic [7:0] vec_op2,
  output logic [7:0] vec_modrm
);
  // ----------------------------------------
  // Classification lanes
  // ----------------------------------------
  idc_dec_t c0;
  idc_dec_t c1;
  idc_classify u_cls0 (.inst(inst0), .opsize32(opsize32), .dec(c0));
  idc_classify u_cls1 (.inst(inst1), .opsize32(opsize32), .dec(c1));

  // ----------------------------------------
  // Grouping per clock
  // ----------------------------------------
  // Second lane only joins when both are short.
  wire pair_ok = c0.valid && c1.valid && (c0.cls == IDC_CLS_SHORT) && (c1.cls == IDC_CLS_SHORT);
  wire [1:0] next_taken = !c0.valid ? 2'b00 : (pair_ok ? 2'b11 : 2'b01);
  // Vector lane 0 starts the sequencer, no direct operations.
  wire next_vec = c0.valid && (c0.cls == IDC_CLS_VECTOR);
  idc_dec_t next_dec1;
  assign next_dec1 = pair_ok ? c1 : '0;

  // ----------------------------------------
  // Unit steering of issued operations
  // ----------------------------------------
  // Lane 0 has three operation slots and lane 1 two, each in program order.
  // An empty slot steers to no unit, so its strobe word stays zero.
  idc_unit_t [4:0] op_sel;
  wire [4:0][3:0] strb;
  assign op_sel = {next_dec1.ops[1], next_dec1.ops[0], c0.ops[2], c0.ops[1], c0.ops[0]};
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_steer
      idc_steer u_st (.unit(op_sel[g]), .strobe(strb[g]));
    end
  endgenerate

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  // Every output comes straight from a flip-flop, and clk_en low freezes all of them.
  // The registers are split by group to keep each process short; all share one enable.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      taken <= 2'b00;
    end else if (clk_en) begin
      taken <= next_taken;
    end
  end

  // Classification results; lane 1 stays zero unless it was paired.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dec0 <= '0;
      dec1 <= '0;
    end else if (clk_en) begin
      dec0 <= c0;
      dec1 <= next_dec1;
    end
  end

  // Unit strobes of lane 0, one word per operation slot.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      unit0_a <= 4'h0;
      unit0_b <= 4'h0;
      unit0_c <= 4'h0;
    end else if (clk_en) begin
      unit0_a <= strb[0];
      unit0_b <= strb[1];
      unit0_c <= strb[2];
    end
  end

  // Unit strobes of lane 1, live only when both lanes are short.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      unit1_a <= 4'h0;
      unit1_b <= 4'h0;
    end else if (clk_en) begin
      unit1_a <= strb[3];
      unit1_b <= strb[4];
    end
  end

  // Sequencer start and bytes.
  // The bytes are copied every enabled cycle; the sequencer reads them only on a start.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      vec_start <= 1'b0;
      vec_op1 <= 8'h00;
      vec_op2 <= 8'h00;
      vec_modrm <= 8'h00;
    end else if (clk_en) begin
      vec_start <= next_vec;
      vec_op1 <= inst0.op1;
      vec_op2 <= inst0.op2;
      vec_modrm <= inst0.modrm;
    end
  end

  // ----------------------------------------
  // Check helpers
  // ----------------------------------------
  // Count the strobe words that name a unit, so the checks can tie them to nops.
  // Each strobe word is one-hot or zero, so one reduction per slot is enough.
  wire [1:0] lane0_issued = 2'(|unit0_a) + 2'(|unit0_b) + 2'(|unit0_c);
  wire [1:0] lane1_issued = 2'(|unit1_a) + 2'(|unit1_b);
  // The modR/M fields of lane 0, named for the checks.
  wire [1:0] chk_form = inst0.modrm[`IDC_MOD_HI:`IDC_MOD_LO];
  wire [2:0] chk_sub = inst0.modrm[`IDC_REG_HI:`IDC_REG_LO];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Pairs only of short.
  a_class_mix: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (taken == 2'b11)
    |-> (dec0.cls == IDC_CLS_SHORT && dec1.cls == IDC_CLS_SHORT))
    else $error("Mixed classes issued together.");

  a_taken_code: assert property (@(posedge clk_sys) disable iff (!reset_n)
    taken[1]
    |-> taken[0])
    else $error("Lane 1 taken without lane 0.");

  a_lane1_idle: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (taken != 2'b11)
    |-> (!dec1.valid && unit1_a == 4'h0 && unit1_b == 4'h0))
    else $error("Lane 1 issued without a pair.");

  a_adj_vector: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clk_en && inst0.valid && (inst0.op1 == `IDC_OP_AAA))
    |=> (dec0.cls == IDC_CLS_VECTOR && vec_start))
    else $error("Adjust opcode not vector.");

  a_adj_pair: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clk_en && inst0.valid && inst0.op1 == `IDC_OP_AAD && inst0.op2 == `IDC_OP_ADJ2)
    |=> (dec0.cls == IDC_CLS_VECTOR && vec_start))
    else $error("Two-byte adjust not vector.");

  a_one_class: assert property (@(posedge clk_sys) disable iff (!reset_n)
    taken[0]
    |-> (dec0.cls != IDC_CLS_NONE))
    else $error("Taken instruction has no class.");

  a_reg_form: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clk_en && inst0.valid && inst0.op1 == `IDC_OP_ADD_LO && chk_form == `IDC_MOD_REG)
    |=> !dec0.mem_form)
    else $error("Register form taken as memory.");

  a_mem_codes: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clk_en && inst0.valid && inst0.op1 == `IDC_OP_ADD_LO && chk_form != `IDC_MOD_REG)
    |=> (dec0.mem_form && dec0.cls == IDC_CLS_LONG))
    else $error("Memory form not recognised.");

  a_reg_index: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clk_en && inst0.valid && inst0.op1 == `IDC_OP_ADD_LO)
    |=> dec0.reg_idx == $past(inst0.modrm[`IDC_REG_HI:`IDC_REG_LO]))
    else $error("Register index wrong.");

  a_wide_size: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clk_en && inst0.valid)
    |=> (dec0.opsize32 == $past(opsize32)))
    else $error("Operand size not carried.");

  a_wide_bit: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clk_en && inst0.valid && inst0.op1 == `IDC_OP_GRP_W)
    |=> dec0.wide)
    else $error("Wide group decoded as byte.");

  a_grp_and: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clk_en && inst0.valid && inst0.op1 == `IDC_OP_GRP_W && chk_sub == `IDC_GRP_AND)
    |=> (dec0.func == IDC_F_AND))
    else $error("Group and not decoded.");

  a_grp_add: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clk_en && inst0.valid && inst0.op1 == `IDC_OP_GRP_B && chk_sub == `IDC_GRP_ADD)
    |=> (dec0.func == IDC_F_ADD))
    else $error("Group add not decoded.");

  a_sx_extend: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clk_en && inst0.valid && inst0.op1 == `IDC_OP_GRP_SX && opsize32)
    |=> (dec0.imm_ext == {{24{$past(inst0.byte_immediate[`IDC_SIGN_BIT])}}, $past(inst0.byte_immediate)}))
    else $error("Immediate not sign-extended.");

  a_adc_vector: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clk_en && inst0.valid && inst0.op1 >= `IDC_OP_ADC_LO && inst0.op1 <= `IDC_OP_ADC_HI)
    |=> (dec0.cls == IDC_CLS_VECTOR && dec0.nops == 2'd0))
    else $error("ADC not vector.");

  a_adc_group: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clk_en && inst0.valid && inst0.op1 == `IDC_OP_GRP_B && chk_sub == `IDC_GRP_ADC)
    |=> (dec0.cls == IDC_CLS_VECTOR && unit0_a == 4'h0))
    else $error("Group carry form not vector.");

  a_short_reg: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (taken[0] && dec0.cls == IDC_CLS_SHORT && !dec0.mem_form)
    |-> (dec0.nops == 2'd1 && (unit0_a[2] || unit0_a[3])))
    else $error("Short register form wrong.");

  a_short_load: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (taken[0] && dec0.cls == IDC_CLS_SHORT && dec0.mem_form)
    |-> (dec0.nops == 2'd2 && unit0_a[0]))
    else $error("Memory source without load.");

  a_nops_lane1: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (taken == 2'b11)
    |-> (lane1_issued == dec1.nops))
    else $error("Lane 1 strobes disagree with count.");

  a_long_order: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (taken[0] && dec0.cls == IDC_CLS_LONG)
    |-> (dec0.nops == 2'd3 && unit0_a[0] && unit0_c[1]))
    else $error("Long order wrong.");

  a_nops_lane0: assert property (@(posedge clk_sys) disable iff (!reset_n)
    taken[0]
    |-> (lane0_issued == dec0.nops))
    else $error("Lane 0 strobes disagree with count.");

  a_byte_x: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (taken[0] && dec0.func != IDC_F_NONE && (!dec0.wide || dec0.sx_imm))
    |-> !unit0_a[2] && !unit0_b[2])
    else $error("Byte op sent to general unit.");

  a_x_long: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (taken[0] && dec0.cls == IDC_CLS_LONG && (!dec0.wide || dec0.sx_imm))
    |-> unit0_b[3])
    else $error("Long byte op not on X unit.");

  a_alu_either: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (taken[0] && dec0.cls == IDC_CLS_SHORT && dec0.wide && !dec0.sx_imm && !dec0.mem_form)
    |-> unit0_a[2])
    else $error("Wide op held to X unit.");

  a_load_unit: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (taken[0] && dec0.cls == IDC_CLS_LONG)
    |-> (unit0_a == 4'h1 && unit0_c == 4'h2))
    else $error("Memory op on wrong unit.");

  a_vec_noops: assert property (@(posedge clk_sys) disable iff (!reset_n)
    vec_start
    |-> (unit0_a == 4'h0 && taken == 2'b01))
    else $error("Vector issued direct operations.");

  a_vec_copy: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en
    |=> (vec_op1 == $past(inst0.op1) && vec_modrm == $past(inst0.modrm)))
    else $error("Sequencer bytes not copied.");

  // A low clock enable holds taken, dec0 and vec_start.
  a_clk_freeze: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !clk_en
    |=> ($stable(taken) && $stable(dec0) && $stable(vec_start)))
    else $error("Outputs moved while frozen.");

endmodule // idc_decoder

//--- hdl/idc_pkg.sv
// Types shared by the integer decoder files.
package idc_pkg;
  typedef enum logic [1:0] {IDC_CLS_NONE, IDC_CLS_SHORT, IDC_CLS_LONG, IDC_CLS_VECTOR} idc_class_t;
  typedef enum logic [2:0] {IDC_U_NONE, IDC_U_LOAD, IDC_U_STORE, IDC_U_ALU, IDC_U_ALUX} idc_unit_t;
  typedef enum logic [1:0] {IDC_F_NONE, IDC_F_ADD, IDC_F_AND} idc_func_t;
  typedef struct packed {
    logic valid;
    logic [7:0] op1;
    logic [7:0] op2;
    logic [7:0] modrm;
    logic [7:0] byte_immediate;
  } idc_inst_t;
  typedef struct packed {
    logic valid;
    idc_class_t cls;
    logic mem_form;
    logic wide;
    logic opsize32;
    logic [2:0] reg_idx;
    logic [2:0] rm_idx;
    idc_func_t func;
    logic sx_imm;
    logic [31:0] imm_ext;
    logic [1:0] nops;
    idc_unit_t [2:0] ops;
  } idc_dec_t;
endpackage

//--- hdl/idc_steer.sv
// Maps one issued operation to its execution unit strobes.
`timescale 1ns/1ps
module idc_steer import idc_pkg::*; (
  input wire idc_unit_t unit,
  output logic [3:0] strobe
);
  // Loads to the load unit, stores to the store unit.
  wire to_load = (unit == IDC_U_LOAD);
  wire to_store = (unit == IDC_U_STORE);
  // Plain arithmetic may use either integer unit.
  wire to_any = (unit == IDC_U_ALU);
  wire to_x = (unit == IDC_U_ALUX);
  assign strobe = {to_x, to_any, to_store, to_load};
endmodule // idc_steer

//--- verification/idc_fetch_model.sv
// Fetch-stage model that presents instruction pairs to the decoder.
`timescale 1ns/1ps
module idc_fetch_model import idc_pkg::*; (
  input wire clk_sys,
  input wire reset_n,
  input wire idc_inst_t next0,
  input wire idc_inst_t next1,
  output idc_inst_t inst0,
  output idc_inst_t inst1
);
  // Pairs change on the falling edge, so the decoder always samples settled bytes.
  // Reset presents invalid lanes; nothing may be offered before release.
  always @(negedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      inst0 <= '0;
      inst1 <= '0;
    end else begin
      inst0 <= next0;
      inst1 <= next1;
    end
  end
endmodule // idc_fetch_model

//--- verification/test_x86_integer_decode_aaa_to_and.sv
// Self-checking testbench for the integer decoder.
`timescale 1ns/1ps
module test_x86_integer_decode_aaa_to_and import idc_pkg::*;;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic opsize32 = 1'b1;
  logic clk_en = 1'b1;
  idc_inst_t next0 = '0;
  idc_inst_t next1 = '0;
  idc_inst_t inst0;
  idc_inst_t inst1;
  logic [1:0] taken;
  idc_dec_t dec0;
  idc_dec_t dec1;
  logic [3:0] u0a, u0b, u0c, u1a, u1b;
  logic vec_start;
  logic [7:0] v1, v2, vm;
  int err_total = 0;
  int num_checks = 0;
  always #10 clk_sys = ~clk_sys;
  idc_fetch_model fm (.clk_sys(clk_sys), .reset_n(reset_n), .next0(next0), .next1(next1), .inst0(inst0), .inst1(inst1));
  // Clock enable changes at the falling edge like every other input.
  idc_decoder uut (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .inst0(inst0), .inst1(inst1),
    .opsize32(opsize32), .taken(taken), .dec0(dec0), .dec1(dec1), .unit0_a(u0a), .unit0_b(u0b), .unit0_c(u0c),
    .unit1_a(u1a), .unit1_b(u1b), .vec_start(vec_start), .vec_op1(v1), .vec_op2(v2), .vec_modrm(vm));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function idc_inst_t mk(input logic [7:0] a, input logic [7:0] b, input logic [7:0] m, input logic [7:0] i);
    mk = '{1'b1, a, b, m, i};
  endfunction
  // Latency is one edge: the pair lands at one falling edge, the answer is read at the next.
  task issue(input idc_inst_t a, input idc_inst_t b);
    next0 = a;
    next1 = b;
    @(negedge clk_sys);
    @(negedge clk_sys);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reg_pair;
    issue(mk(8'h00, 8'h00, 8'hC1, 8'h00), mk(8'h01, 8'h00, 8'hD8, 8'h00));
    chk(taken, 2'b11);
    chk({dec0.cls, dec1.cls}, {IDC_CLS_SHORT, IDC_CLS_SHORT});
    chk({dec0.mem_form, dec1.mem_form, dec0.reg_idx, dec1.reg_idx}, {2'b00, 3'h0, 3'h3});
    chk({dec0.wide, dec1.wide}, 2'b01);
    chk({u0a, u1a}, {4'h8, 4'h4});
  endtask
  task t_mem_dest;
    logic [7:0] mods [3] = '{8'h00, 8'h45, 8'h80};
    for (int k = 0; k < 3; k++) begin
      issue(mk(8'h01, 8'h00, mods[k], 8'h00), mk(8'h00, 8'h00, 8'hC0, 8'h00));
      chk(taken, 2'b01);
      chk({dec0.cls, dec0.mem_form}, {IDC_CLS_LONG, 1'b1});
      chk({u0a, u0b, u0c}, {4'h1, 4'h4, 4'h2});
    end
  endtask
  task t_mem_src;
    issue(mk(8'h03, 8'h00, 8'h45, 8'h00), mk(8'h01, 8'h00, 8'hC0, 8'h00));
    chk({taken, dec0.cls, dec0.nops}, {2'b11, IDC_CLS_SHORT, 2'd2});
    chk({u0a, u0b}, {4'h1, 4'h4});
    chk({u1a, u1b}, {4'h4, 4'h0});
  endtask
  task t_vector;
    logic [23:0] tbl [13] = '{24'h370000, 24'h3F0000, 24'hD50A00, 24'hD40A00, 24'h1000C0, 24'h110000,
      24'h1200C5, 24'h130080, 24'h140000, 24'h150000, 24'h8000D0, 24'h810050, 24'h830010};
    for (int k = 0; k < 13; k++) begin
      issue(mk(tbl[k][23:16], tbl[k][15:8], tbl[k][7:0], 8'h01), mk(8'h00, 8'h00, 8'hC0, 8'h00));
      chk(taken, 2'b01);
      chk({vec_start, dec0.cls, dec0.nops}, {1'b1, IDC_CLS_VECTOR, 2'd0});
      chk({v1, v2}, tbl[k][23:8]);
      chk(vm, tbl[k][7:0]);
    end
  endtask
  task t_group;
    issue(mk(8'h83, 8'h00, 8'hC1, 8'h80), '0);
    chk(dec0.imm_ext, 32'hFFFF_FF80);
    chk({dec0.cls, dec0.func, u0a}, {IDC_CLS_SHORT, IDC_F_ADD, 4'h8});
    issue(mk(8'h80, 8'h00, 8'hE2, 8'h0F), '0);
    chk({dec0.func, dec0.rm_idx, u0a}, {IDC_F_AND, 3'h2, 4'h8});
    opsize32 = 1'b0;
    issue(mk(8'h81, 8'h00, 8'hC2, 8'h0F), '0);
    chk({dec0.func, dec0.opsize32, u0a}, {IDC_F_ADD, 1'b0, 4'h4});
    opsize32 = 1'b1;
    issue('0, mk(8'h00, 8'h00, 8'hC0, 8'h00));
    chk({taken, vec_start}, 3'b000);
  endtask
  // Freeze, then a reset in mid-run, then an accumulator form.
  task t_freeze;
    issue(mk(8'h01, 8'h00, 8'hC3, 8'h00), '0);
    clk_en = 1'b0;
    issue(mk(8'h37, 8'h00, 8'h00, 8'h00), '0);
    chk({taken, dec0.cls, u0a, vec_start}, {2'b01, IDC_CLS_SHORT, 4'h4, 1'b0});
    clk_en = 1'b1;
    reset_n = 1'b0;
    @(negedge clk_sys);
    chk({taken, dec0.valid, u0a}, 7'h00);
    reset_n = 1'b1;
    issue(mk(8'h04, 8'h00, 8'h00, 8'h05), '0);
    chk({taken, dec0.cls, dec0.reg_idx, u0a}, {2'b01, IDC_CLS_SHORT, 3'h0, 4'h8});
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // A hung run counts as a mismatch and still reaches the verdict.
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    print_verdict;
  end
  initial begin
    repeat (12) @(negedge clk_sys);
    chk(taken, 2'b00);
    reset_n = 1'b1;
    t_reg_pair;
    t_mem_dest;
    t_mem_src;
    t_vector;
    t_group;
    t_freeze;
    print_verdict;
  end
endmodule // test_x86_integer_decode_aaa_to_and
